/* File: src/fsk_tx_control.sv */
// top: fsk transmit control, divider select, data pin direction, ahb-lite registers
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module fsk_tx_control
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe_out,
  input wire logic demod_data_in,
  input wire logic up_pulse_in,
  input wire logic down_pulse_in,
  output logic amp_enable_out,
  output logic [2:0] amp_level_out,
  output logic [23:0] synth_divider_out,
  output logic tx_bit_out,
  output logic [7:0] crystal_trim_value_out,
  output logic low_noise_amp_bypass_out
);
  // ----------------------------------------------------------------
  // bus address phase capture
  // ----------------------------------------------------------------
  logic wr_pend_q;
  logic wr_pend_d;
  logic [7:0] wr_idx_q;
  logic [7:0] wr_idx_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic [7:0] addr_idx;
  logic addr_phase;

  assign addr_idx = haddr_in[fsk_tx_pkg::ADDR_LSB +: fsk_tx_pkg::IDX_W];
  assign addr_phase = hsel_in && hready_in && htrans_in[1];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] mode_reg_q;
  logic [7:0] mode_reg_d;
  logic [7:0] strength_reg_q;
  logic [7:0] strength_reg_d;
  logic [23:0] div0_q;
  logic [23:0] div0_d;
  logic [23:0] div1_q;
  logic [23:0] div1_d;
  logic [3:0] est_ctrl_q;
  logic [3:0] est_ctrl_d;
  logic [7:0] trim_q;
  logic [7:0] trim_d;
  logic est_clear;
  logic [7:0] estimate;
  logic [7:0] wbyte;

  assign wbyte = hwdata_in[7:0];

  always_comb
  begin
    mode_reg_d = mode_reg_q;
    strength_reg_d = strength_reg_q;
    div0_d = div0_q;
    div1_d = div1_q;
    est_ctrl_d = est_ctrl_q;
    trim_d = trim_q;
    est_clear = 1'b0;
    wr_pend_d = addr_phase && hwrite_in;
    wr_idx_d = addr_phase ? addr_idx : wr_idx_q;
    if (wr_pend_q)
    begin
      case (wr_idx_q)
        fsk_tx_pkg::IDX_TX_POWER_AND_MODE_CONTROL:
          mode_reg_d = wbyte | fsk_tx_pkg::MODE_REG_FIXED_MASK;
        fsk_tx_pkg::IDX_SIGNAL_STRENGTH_AND_PREFILTER_CONTROL:
          strength_reg_d = (wbyte & ~fsk_tx_pkg::STRENGTH_REG_FIXED_MASK)
                         | fsk_tx_pkg::STRENGTH_REG_FIXED_VAL;
        fsk_tx_pkg::IDX_DIVIDER_SET_ZERO:
          div0_d = hwdata_in[23:0];
        fsk_tx_pkg::IDX_DIVIDER_SET_ONE:
          div1_d = hwdata_in[23:0];
        fsk_tx_pkg::IDX_ESTIMATOR_CONTROL:
        begin
          // writing the control restarts a measurement from zero
          est_ctrl_d = hwdata_in[3:0];
          est_clear = 1'b1;
        end
        fsk_tx_pkg::IDX_CRYSTAL_TRIM:
          trim_d = wbyte;
        default:
          est_clear = 1'b0;
      endcase
    end
    hrdata_d = 32'h00000000;
    if (addr_phase && !hwrite_in)
    begin
      case (addr_idx)
        fsk_tx_pkg::IDX_TX_POWER_AND_MODE_CONTROL:
          hrdata_d = {24'h000000, mode_reg_q};
        fsk_tx_pkg::IDX_SIGNAL_STRENGTH_AND_PREFILTER_CONTROL:
          hrdata_d = {24'h000000, strength_reg_q};
        fsk_tx_pkg::IDX_DIVIDER_SET_ZERO:
          hrdata_d = {8'h00, div0_q};
        fsk_tx_pkg::IDX_DIVIDER_SET_ONE:
          hrdata_d = {8'h00, div1_q};
        fsk_tx_pkg::IDX_ESTIMATOR_CONTROL:
          hrdata_d = {28'h0000000, est_ctrl_q};
        fsk_tx_pkg::IDX_ESTIMATOR_RESULT:
          hrdata_d = {24'h000000, estimate};
        fsk_tx_pkg::IDX_CRYSTAL_TRIM:
          hrdata_d = {24'h000000, trim_q};
        default:
          hrdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
      hrdata_q <= 32'h00000000;
      mode_reg_q <= fsk_tx_pkg::MODE_REG_RESET;
      strength_reg_q <= fsk_tx_pkg::STRENGTH_REG_RESET;
      div0_q <= fsk_tx_pkg::DIV_RESET;
      div1_q <= fsk_tx_pkg::DIV_RESET;
      est_ctrl_q <= fsk_tx_pkg::EST_CTRL_RESET;
      trim_q <= fsk_tx_pkg::TRIM_RESET;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      wr_idx_q <= wr_idx_d;
      hrdata_q <= hrdata_d;
      mode_reg_q <= mode_reg_d;
      strength_reg_q <= strength_reg_d;
      div0_q <= div0_d;
      div1_q <= div1_d;
      est_ctrl_q <= est_ctrl_d;
      trim_q <= trim_d;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] pins_raw;

  assign pins_raw = {serial_data_pin_in, up_pulse_in, down_pulse_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      always_ff @(posedge clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end
        else
        begin
          sync1_q[gi] <= pins_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // pulses are levels of one pulse each; detect rising edge after sync
  logic up_prev_q;
  logic dn_prev_q;
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      up_prev_q <= 1'b0;
      dn_prev_q <= 1'b0;
    end
    else
    begin
      up_prev_q <= sync2_q[1];
      dn_prev_q <= sync2_q[0];
    end
  end

  freq_error_counter i_freq_error_counter
  (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .clear_in(est_clear),
    .mode_in(est_ctrl_q[1:0]),
    .up_pulse_in(sync2_q[1] && !up_prev_q),
    .down_pulse_in(sync2_q[0] && !dn_prev_q),
    .freq_error_estimate_out(estimate)
  );

  // ----------------------------------------------------------------
  // transmit datapath
  // ----------------------------------------------------------------
  logic [1:0] op_mode;
  logic is_tx;
  logic [2:0] amp_field;
  logic amp_en_q;
  logic amp_en_d;
  logic [2:0] amp_lvl_q;
  logic [2:0] amp_lvl_d;
  logic [23:0] div_sel_q;
  logic [23:0] div_sel_d;
  logic tx_bit_q;
  logic tx_bit_d;
  logic pin_out_q;
  logic pin_out_d;
  logic pin_oe_q;
  logic pin_oe_d;

  assign op_mode = mode_reg_q[fsk_tx_pkg::F_MODE_HI:fsk_tx_pkg::F_MODE_LO];
  assign is_tx = (op_mode == fsk_tx_pkg::OPMODE_TX);
  assign amp_field = mode_reg_q[fsk_tx_pkg::F_AMP_HI:fsk_tx_pkg::F_AMP_LO];

  always_comb
  begin
    // level code 1 is the top step, each higher code about 3 db down
    amp_lvl_d = amp_field;
    amp_en_d = is_tx && (amp_field != fsk_tx_pkg::AMP_OFF);
    tx_bit_d = is_tx ? sync2_q[2] : 1'b0;
    div_sel_d = (is_tx && sync2_q[2]) ? div1_q : div0_q;
    pin_oe_d = (op_mode == fsk_tx_pkg::OPMODE_RX);
    pin_out_d = pin_oe_d ? demod_data_in : 1'b0;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      amp_en_q <= 1'b0;
      amp_lvl_q <= fsk_tx_pkg::AMP_OFF;
      div_sel_q <= fsk_tx_pkg::DIV_RESET;
      tx_bit_q <= 1'b0;
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end
    else
    begin
      amp_en_q <= amp_en_d;
      amp_lvl_q <= amp_lvl_d;
      div_sel_q <= div_sel_d;
      tx_bit_q <= tx_bit_d;
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  assign hrdata_out = hrdata_q;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign serial_data_pin_out = pin_out_q;
  assign serial_data_pin_oe_out = pin_oe_q;
  assign amp_enable_out = amp_en_q;
  assign amp_level_out = amp_lvl_q;
  assign synth_divider_out = div_sel_q;
  assign tx_bit_out = tx_bit_q;
  assign crystal_trim_value_out = trim_q;
  assign low_noise_amp_bypass_out = mode_reg_q[fsk_tx_pkg::F_LNA_BYPASS];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_amp_off;
    @(posedge clk_in) disable iff (!resetn_in)
    (amp_field == 3'h0) |=> !amp_enable_out;
  endproperty
  a_amp_off: assert property (p_amp_off)
    else $error("amplifier on with level zero");

  property p_amp_on;
    @(posedge clk_in) disable iff (!resetn_in)
    (is_tx && amp_field != 3'h0) |=> amp_enable_out && amp_level_out == $past(amp_field);
  endproperty
  a_amp_on: assert property (p_amp_on)
    else $error("amplifier not on at nonzero level");

  property p_level;
    @(posedge clk_in) disable iff (!resetn_in)
    1'b1 |=> amp_level_out == $past(amp_field);
  endproperty
  a_level: assert property (p_level)
    else $error("amplifier level does not follow field");

  property p_div_one;
    @(posedge clk_in) disable iff (!resetn_in)
    (is_tx && sync2_q[2]) |=> synth_divider_out == $past(div1_q);
  endproperty
  a_div_one: assert property (p_div_one)
    else $error("bit one did not select divider set one");

  property p_div_zero;
    @(posedge clk_in) disable iff (!resetn_in)
    (is_tx && !sync2_q[2]) |=> synth_divider_out == $past(div0_q);
  endproperty
  a_div_zero: assert property (p_div_zero)
    else $error("bit zero did not select divider set zero");

  property p_pin_dir;
    @(posedge clk_in) disable iff (!resetn_in)
    is_tx |=> !serial_data_pin_oe_out;
  endproperty
  a_pin_dir: assert property (p_pin_dir)
    else $error("data pin driven in transmit");

  property p_pin_rx;
    @(posedge clk_in) disable iff (!resetn_in)
    (op_mode == 2'b00) |=> serial_data_pin_oe_out && serial_data_pin_out == $past(demod_data_in);
  endproperty
  a_pin_rx: assert property (p_pin_rx)
    else $error("data pin not driven with demodulated data in receive");

  property p_est_both;
    @(posedge clk_in) disable iff (!resetn_in)
    (est_ctrl_q[1:0] == fsk_tx_pkg::EST_BOTH && sync2_q[1] && !up_prev_q
      && !(sync2_q[0] && !dn_prev_q)
      && !wr_pend_q) |=> estimate == $past(estimate) + 8'h01;
  endproperty
  a_est_both: assert property (p_est_both)
    else $error("up pulse did not increment estimate");

  c_tx_one: cover property (@(posedge clk_in) disable iff (!resetn_in) is_tx && sync2_q[2]);
  c_rx: cover property (@(posedge clk_in) disable iff (!resetn_in) serial_data_pin_oe_out);
  c_wrap: cover property (@(posedge clk_in) disable iff (!resetn_in)
    estimate == 8'h80 ##1 estimate == 8'h7f);
endmodule : fsk_tx_control
`default_nettype wire

/* File: src/fsk_tx_pkg.sv */
// package: register map, fields and constants of the fsk transmit control block
package fsk_tx_pkg;
  // ----------------------------------------------------------------
  // register indices (printed offsets) and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_TX_POWER_AND_MODE_CONTROL = 8'h00;
  localparam logic [7:0] IDX_SIGNAL_STRENGTH_AND_PREFILTER_CONTROL = 8'h01;
  localparam logic [7:0] IDX_DIVIDER_SET_ZERO = 8'h02;
  localparam logic [7:0] IDX_DIVIDER_SET_ONE = 8'h03;
  localparam logic [7:0] IDX_ESTIMATOR_CONTROL = 8'h04;
  localparam logic [7:0] IDX_ESTIMATOR_RESULT = 8'h05;
  localparam logic [7:0] IDX_CRYSTAL_TRIM = 8'h06;
  localparam logic [7:0] IDX_LAST = 8'h06;
  localparam int ADDR_LSB = 2;
  localparam int IDX_W = 8;
  // ----------------------------------------------------------------
  // field positions in the power and mode register
  // ----------------------------------------------------------------
  localparam int F_LNA_BYPASS = 7;
  localparam int F_AMP_HI = 6;
  localparam int F_AMP_LO = 4;
  localparam int F_SYNC_EN = 3;
  localparam int F_MODE_HI = 2;
  localparam int F_MODE_LO = 1;
  localparam logic [7:0] MODE_REG_RESET = 8'h01;
  localparam logic [7:0] MODE_REG_FIXED_MASK = 8'h01;
  localparam logic [7:0] STRENGTH_REG_RESET = 8'h80;
  localparam logic [7:0] STRENGTH_REG_FIXED_MASK = 8'hf0;
  localparam logic [7:0] STRENGTH_REG_FIXED_VAL = 8'h80;
  localparam logic [2:0] AMP_OFF = 3'h0;
  localparam logic [2:0] AMP_MAX = 3'h1;
  // divider set word: ref [23:16] main [15:8] swallow [7:0]
  localparam int DIV_W = 24;
  localparam logic [23:0] DIV_RESET = 24'h000000;
  // ----------------------------------------------------------------
  // operating modes (mode field)
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    OPMODE_RX = 2'b00,
    OPMODE_TX = 2'b01,
    OPMODE_STBY = 2'b10,
    OPMODE_DOWN = 2'b11
  } op_mode_t;
  // ----------------------------------------------------------------
  // estimator modes and reset values
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    EST_OFF = 2'b00,
    EST_UP = 2'b01,
    EST_DOWN = 2'b10,
    EST_BOTH = 2'b11
  } est_mode_t;
  localparam logic [3:0] EST_CTRL_RESET = 4'h0;
  localparam logic [7:0] TRIM_RESET = 8'h80;
  localparam logic [31:0] BUS_OKAY = 32'h00000000;
endpackage : fsk_tx_pkg

/* File: src/freq_error_counter.sv */
// frequency error estimator: signed wrapping up/down pulse counter
`timescale 1ns/100ps
`default_nettype none
module freq_error_counter
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic clear_in,
  input wire logic [1:0] mode_in,
  input wire logic up_pulse_in,
  input wire logic down_pulse_in,
  output logic [7:0] freq_error_estimate_out
);
  logic [7:0] count_q;
  logic [7:0] count_d;

  always_comb
  begin
    count_d = count_q;
    // 8-bit arithmetic wraps modulo 256, so -128 minus one reads 127
    case (fsk_tx_pkg::est_mode_t'(mode_in))
      fsk_tx_pkg::EST_UP:
      begin
        if (up_pulse_in)
          count_d = count_q + 8'h01;
      end
      fsk_tx_pkg::EST_DOWN:
      begin
        if (down_pulse_in)
          count_d = count_q - 8'h01;
      end
      fsk_tx_pkg::EST_BOTH:
      begin
        if (up_pulse_in && !down_pulse_in)
          count_d = count_q + 8'h01;
        else if (down_pulse_in && !up_pulse_in)
          count_d = count_q - 8'h01;
      end
      default:
      begin
        count_d = count_q;
      end
    endcase
    if (clear_in)
      count_d = 8'h00;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      count_q <= 8'h00;
    else
      count_q <= count_d;
  end

  assign freq_error_estimate_out = count_q;

  // mode bit 1 set means down pulses count, in down-only and combined modes
  property p_wrap_down;
    @(posedge clk_in) disable iff (!resetn_in)
    (count_q == 8'h80 && mode_in[1] && down_pulse_in && !up_pulse_in && !clear_in)
      |=> count_q == 8'h7f;
  endproperty
  a_wrap_down: assert property (p_wrap_down)
    else $error("estimate did not wrap from -128 to 127");

  property p_both_down;
    @(posedge clk_in) disable iff (!resetn_in)
    (mode_in == fsk_tx_pkg::EST_BOTH && down_pulse_in && !up_pulse_in && !clear_in)
      |=> count_q == $past(count_q) - 8'h01;
  endproperty
  a_both_down: assert property (p_both_down)
    else $error("down pulse did not decrement estimate");
endmodule : freq_error_counter
`default_nettype wire

/* File: dv/host_link_model.sv */
// host link model: controller side of the shared serial data pin
`timescale 1ns/100ps
`default_nettype none
module host_link_model
(
  input wire logic bit_in,
  input wire logic dev_oe_in,
  input wire logic dev_data_in,
  output logic pin_level_out
);
  // host drives its tx bit only while the device leaves the pin
  assign pin_level_out = dev_oe_in ? dev_data_in : bit_in;
endmodule : host_link_model
`default_nettype wire

/* File: dv/test_fsk_tx_control.sv */
// testbench: fsk transmit control driven over ahb-lite with a host link model
`timescale 1ns/100ps
`default_nettype none
module test_fsk_tx_control;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic hready, hresp, pin, dev_pin, dev_oe, amp_en, tx_bit, lna;
  logic demod = 1'b0;
  logic up = 1'b0;
  logic dn = 1'b0;
  logic host_bit = 1'b0;
  logic [2:0] amp_lvl;
  logic [23:0] divider;
  logic [7:0] trim;
  logic [31:0] rd;
  int err_total = 0;
  int n_checks = 0;

  always #50 clk = ~clk;

  fsk_tx_control i_fsk_tx_control (.clk_in(clk), .resetn_in(rst_n), .hsel_in(1'b1),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .serial_data_pin_in(pin), .serial_data_pin_out(dev_pin),
    .serial_data_pin_oe_out(dev_oe), .demod_data_in(demod), .up_pulse_in(up),
    .down_pulse_in(dn), .amp_enable_out(amp_en), .amp_level_out(amp_lvl),
    .synth_divider_out(divider), .tx_bit_out(tx_bit), .crystal_trim_value_out(trim),
    .low_noise_amp_bypass_out(lna));

  host_link_model i_host_link_model (.bit_in(host_bit), .dev_oe_in(dev_oe),
    .dev_data_in(dev_pin), .pin_level_out(pin));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task report_and_stop;
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task step(input int n);
    repeat (n) @(posedge clk);
  endtask : step

  task wait_ready;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
  endtask : wait_ready

  task bus(input logic [7:0] idx, input logic wr, input logic [31:0] d);
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask : bus

  task rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string what);
    bus(idx, 1'b0, 32'h0);
    chk(rd, exp, what);
  endtask : rd_chk

  task pulse(input int n, input logic is_up);
    repeat (n)
    begin
      if (is_up)
        up <= 1'b1;
      else
        dn <= 1'b1;
      step(2);
      up <= 1'b0;
      dn <= 1'b0;
      step(2);
    end
  endtask : pulse

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    rd_chk(fsk_tx_pkg::IDX_TX_POWER_AND_MODE_CONTROL, 32'h01, "mode reg reset");
    rd_chk(fsk_tx_pkg::IDX_SIGNAL_STRENGTH_AND_PREFILTER_CONTROL, 32'h80, "strength reset");
    rd_chk(fsk_tx_pkg::IDX_CRYSTAL_TRIM, 32'h80, "trim reg reset");
    chk(trim, 32'h80, "trim out reset");
    chk(amp_en, 32'h0, "amp off at reset");
    chk(hresp, 32'h0, "okay response");
    bus(8'h07, 1'b1, 32'h5a);
    rd_chk(8'h07, 32'h0, "unmapped read");
    bus(fsk_tx_pkg::IDX_SIGNAL_STRENGTH_AND_PREFILTER_CONTROL, 1'b1, 32'h0f);
    rd_chk(fsk_tx_pkg::IDX_SIGNAL_STRENGTH_AND_PREFILTER_CONTROL, 32'h8f, "fixed bits");
  endtask : t_reset

  task t_amp;
    for (int l = 0; l < 8; l++)
    begin
      bus(fsk_tx_pkg::IDX_TX_POWER_AND_MODE_CONTROL, 1'b1, {25'h0, l[2:0], 4'h3});
      step(2);
      chk(amp_en, {31'h0, l != 0}, "amp enable");
      chk(amp_lvl, l, "amp level");
      rd_chk(fsk_tx_pkg::IDX_TX_POWER_AND_MODE_CONTROL, {25'h0, l[2:0], 4'h3}, "mode rb");
    end
    bus(fsk_tx_pkg::IDX_TX_POWER_AND_MODE_CONTROL, 1'b1, 32'h91);
    step(2);
    chk(amp_en, 32'h0, "amp off outside tx");
    chk(lna, 32'h1, "lna bypass");
  endtask : t_amp

  task t_divider;
    bus(fsk_tx_pkg::IDX_DIVIDER_SET_ZERO, 1'b1, 32'h123456);
    bus(fsk_tx_pkg::IDX_DIVIDER_SET_ONE, 1'b1, 32'hfedcba);
    rd_chk(fsk_tx_pkg::IDX_DIVIDER_SET_ONE, 32'hfedcba, "set one rb");
    bus(fsk_tx_pkg::IDX_TX_POWER_AND_MODE_CONTROL, 1'b1, 32'h13);
    for (int i = 0; i < 4; i++)
    begin
      host_bit <= i[0];
      step(4);
      chk(tx_bit, {31'h0, i[0]}, "tx bit");
      chk(divider, i[0] ? 32'hfedcba : 32'h123456, "divider set");
    end
  endtask : t_divider

  task t_pin;
    chk(dev_oe, 32'h0, "pin input in tx");
    bus(fsk_tx_pkg::IDX_TX_POWER_AND_MODE_CONTROL, 1'b1, 32'h01);
    step(3);
    chk(dev_oe, 32'h1, "pin output in rx");
    chk(divider, 32'h123456, "set zero in rx");
    // host still holds a one here, so a leak through the pin would show
    chk(tx_bit, 32'h0, "no tx bit in rx");
    for (int d = 0; d < 2; d++)
    begin
      demod <= d[0];
      step(2);
      chk(dev_pin, {31'h0, d[0]}, "demod on pin");
    end
  endtask : t_pin

  task est(input fsk_tx_pkg::est_mode_t m, input int u, input int n, input logic [7:0] e);
    bus(fsk_tx_pkg::IDX_ESTIMATOR_CONTROL, 1'b1, {30'h0, m});
    pulse(u, 1'b1);
    pulse(n, 1'b0);
    step(6);
    rd_chk(fsk_tx_pkg::IDX_ESTIMATOR_RESULT, {24'h0, e}, "estimate");
  endtask : est

  // host trim step against the sign of the estimate
  task trim_step(input logic [7:0] now);
    logic [7:0] nxt;
    nxt = $signed(rd[7:0]) > 0 ? now - 8'h01 : now + 8'h01;
    bus(fsk_tx_pkg::IDX_CRYSTAL_TRIM, 1'b1, {24'h0, nxt});
    step(2);
    chk(trim, {24'h0, nxt}, "trim output");
  endtask : trim_step

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    step(12);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_amp();
    t_divider();
    t_pin();
    est(fsk_tx_pkg::EST_OFF, 3, 3, 8'h00);
    est(fsk_tx_pkg::EST_UP, 5, 2, 8'h05);
    est(fsk_tx_pkg::EST_DOWN, 2, 3, 8'hfd);
    est(fsk_tx_pkg::EST_BOTH, 7, 2, 8'h05);
    trim_step(8'h80);
    est(fsk_tx_pkg::EST_BOTH, 0, 4, 8'hfc);
    trim_step(8'h7f);
    est(fsk_tx_pkg::EST_BOTH, 0, 129, 8'h7f);
    report_and_stop();
  end

  initial
  begin
    step(20000);
    err_total++;
    report_and_stop();
  end
endmodule : test_fsk_tx_control
`default_nettype wire
